// *** core/prc_counter.sv ***
// Presettable 4-bit counter with a divide-by-two first stage and a separate
// divide-by-five (decade build) or divide-by-eight (binary build) second stage.
// Assumes all inputs, including both stage clocks, are synchronous to core_clk_i
// and that each stage clock holds each level for at least one core_clk_i cycle.
//
// Summary of operation
// RULE1 - Each stage advances only on a falling edge of its own clock input.
// RULE2 - First clock drives the single-bit stage; second clock drives the three-bit stage.
// RULE3 - Decade build, bit 0 feeding second clock: counts 0 to 9, then 0.
// RULE4 - Decade build, bit 3 feeding first clock: bi-quinary 0-4 low, 5-9 high.
// RULE5 - Decade build: first stage divides by two, second stage by five.
// RULE6 - Bi-quinary: first-stage output is a symmetric square wave at clock/10.
// RULE7 - Binary build: divide by two, four, eight, or sixteen when cascaded.
// RULE8 - Binary build, bit 0 feeding second clock: counts 0 to 15, then 0.
// RULE9 - While preset strobe is low, each output follows its preset data input.
// RULE10 - Low on the common clear input forces all four outputs low.
// RULE11 - Clear wins over preset when both are active.
// RULE12 - Clock edges are ignored during preset; counting resumes from loaded value.
`timescale 1ns/1ns
`default_nettype none

module prc_counter #(
    parameter bit DECADE_MODE = 1'b1
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    input  wire logic              first_stage_clk_n_i,
    input  wire logic              second_stage_clk_n_i,
    input  wire logic              preset_strobe_n_i,
    input  wire logic              clear_all_n_i,
    input  wire prc_pkg::prc_count_t preset_value_i,
    output var  prc_pkg::prc_count_t count_value_o
);

    // Edge history of the two stage clocks
    logic                first_clk_q;
    logic                first_clk_d;
    logic                second_clk_q;
    logic                second_clk_d;

    // Arming flag for the edge detectors
    logic                armed_q;
    logic                armed_d;

    // Counter state
    prc_pkg::prc_count_t count_q;
    prc_pkg::prc_count_t count_d;

    // Flat views for the per-bit selection
    logic [3:0]          count_flat;
    logic [3:0]          preset_flat;
    logic [3:0]          reset_flat;
    logic [3:0]          counted_flat;
    logic [3:0]          select_flat;

    // Operating mode decode
    wire logic clear_active;
    wire logic preset_active;
    wire logic count_active;

    assign clear_active  = ~clear_all_n_i;                          // RULE10 RULE11
    assign preset_active = clear_all_n_i & ~preset_strobe_n_i;      // RULE9 RULE11
    assign count_active  = clear_all_n_i & preset_strobe_n_i;       // RULE12

    // Edge history follows the pins on every enabled cycle, even during preset or clear
    assign first_clk_d  = first_stage_clk_n_i;
    assign second_clk_d = second_stage_clk_n_i;

    // History cannot hold a pin level in reset, so the first sample only arms
    // the detectors; a clock that is already low at release is not an edge
    assign armed_d = prc_pkg::ARMED_SET;

    // Falling-edge detectors; rising edges produce nothing
    wire logic first_fall_raw;
    wire logic second_fall_raw;
    wire logic first_fall;
    wire logic second_fall;

    assign first_fall_raw  = first_clk_q & ~first_stage_clk_n_i;   // RULE1
    assign second_fall_raw = second_clk_q & ~second_stage_clk_n_i; // RULE1
    assign first_fall      = armed_q & first_fall_raw;             // RULE1 RULE2
    assign second_fall     = armed_q & second_fall_raw;            // RULE1 RULE2

    // First stage: a plain toggle on its own clock
    wire logic lower_toggled;
    wire logic lower_next;

    assign lower_toggled = ~count_q.lower;                                  // RULE5 RULE7
    assign lower_next    = first_fall ? lower_toggled : count_q.lower;      // RULE5 RULE6 RULE7

    // Second stage: five states in the decade build, eight in the binary build
    wire logic [2:0] upper_last;
    wire logic       upper_at_last;
    wire logic       upper_past_last;
    wire logic       upper_wrap;
    wire logic [2:0] upper_plus_one;
    wire logic [2:0] upper_inc;
    wire logic [2:0] upper_next;

    assign upper_last = DECADE_MODE ? prc_pkg::UPPER_LAST_DECADE
                                    : prc_pkg::UPPER_LAST_BINARY;           // RULE5 RULE7

    assign upper_at_last   = (count_q.upper == upper_last);                 // RULE3 RULE8
    // Out-of-range preset values in the decade build fall back to zero rather than run on
    assign upper_past_last = (count_q.upper > upper_last);
    assign upper_wrap      = upper_at_last | upper_past_last;               // RULE3 RULE4 RULE8

    assign upper_plus_one  = count_q.upper + prc_pkg::UPPER_ONE;
    // Wrap of the top bit is what clocks the first stage in bi-quinary use
    assign upper_inc       = upper_wrap ? prc_pkg::UPPER_ZERO
                                        : upper_plus_one;                   // RULE4 RULE6

    assign upper_next = second_fall ? upper_inc : count_q.upper;           // RULE2 RULE7

    // Flattened views for the per-bit selection below
    assign count_flat   = count_q;
    assign preset_flat  = preset_value_i;
    assign reset_flat   = prc_pkg::COUNT_RESET;
    assign counted_flat = {upper_next, lower_next};

    // Clear over preset over counting, chosen bit by bit
    generate
        for (genvar bit_idx = 0; bit_idx < 4; bit_idx++) begin : g_bit_sel
            wire logic bit_counted;
            wire logic bit_loaded;
            wire logic bit_cleared;

            assign bit_counted = count_active  & counted_flat[bit_idx];     // RULE12
            assign bit_loaded  = preset_active & preset_flat[bit_idx];      // RULE9
            assign bit_cleared = clear_active  & reset_flat[bit_idx];       // RULE10 RULE11

            assign select_flat[bit_idx] = bit_counted | bit_loaded | bit_cleared;
        end
    endgenerate

    assign count_d = select_flat;

    // Arming flag
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q <= prc_pkg::ARMED_RESET;
        end else if (clk_en_i) begin
            armed_q <= armed_d;
        end
    end

    // First-stage clock history
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            first_clk_q <= prc_pkg::STAGE_CLK_IDLE;
        end else if (clk_en_i) begin
            first_clk_q <= first_clk_d;
        end
    end

    // Second-stage clock history
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            second_clk_q <= prc_pkg::STAGE_CLK_IDLE;
        end else if (clk_en_i) begin
            second_clk_q <= second_clk_d;
        end
    end

    // Counter state; a low enable freezes it together with the history
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= prc_pkg::COUNT_RESET;
        end else if (clk_en_i) begin
            count_q <= count_d;
        end
    end

    // Outputs straight from the flip-flops
    assign count_value_o = count_q;

    // Unused OR reduction of the flat copy, kept as an any-bit-set view of the state
    wire logic count_any;
    assign count_any = |count_flat;

endmodule

`default_nettype wire

// *** core/prc_pkg.sv ***
// Package for the presettable ripple counter: widths, reset values, stage limits.
// Assumes a single clock domain; nothing here is tied to a bus.
package prc_pkg;

    localparam int unsigned COUNT_WIDTH   = 4;
    localparam int unsigned UPPER_WIDTH   = 3;

    // Last value of the second stage before it wraps
    localparam logic [2:0]  UPPER_LAST_DECADE = 3'h4;
    localparam logic [2:0]  UPPER_LAST_BINARY = 3'h7;
    localparam logic [2:0]  UPPER_ZERO        = 3'h0;
    localparam logic [2:0]  UPPER_ONE         = 3'h1;

    // Reset values
    localparam logic        LOWER_RESET       = 1'h0;
    localparam logic [2:0]  UPPER_RESET       = 3'h0;
    // Stage clocks idle high, so a first low after reset is seen as an edge only if it was high first
    localparam logic        STAGE_CLK_IDLE    = 1'h1;
    // Edge detection stays disarmed until one enabled sample has been taken
    localparam logic        ARMED_RESET       = 1'h0;
    localparam logic        ARMED_SET         = 1'h1;

    // Counter state: first stage in bit 0, second stage in bits 3..1
    typedef struct packed {
        logic [2:0] upper;
        logic       lower;
    } prc_count_t;

    localparam prc_count_t COUNT_RESET = '{upper: UPPER_RESET, lower: LOWER_RESET};

endpackage

// *** test/prc_chk.sv ***
// Port checker for prc_counter; bound below, sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module prc_chk #(parameter bit DECADE_MODE = 1'b1) (input wire logic core_clk_i, rst_n_i, clk_en_i,
    first_stage_clk_n_i, second_stage_clk_n_i, preset_strobe_n_i, clear_all_n_i,
    input wire prc_pkg::prc_count_t preset_value_i, count_value_o);
    wire logic c1 = first_stage_clk_n_i, c2 = second_stage_clk_n_i, ld = clear_all_n_i & !preset_strobe_n_i;
    wire logic go = clk_en_i & clear_all_n_i & preset_strobe_n_i;
    wire logic [2:0] lim = DECADE_MODE ? 3'h4 : 3'h7;
    wire prc_pkg::prc_count_t q = count_value_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_quiet; go && !$fell(c1) && !$fell(c2); endsequence
    a_clear_zero: assert property (clk_en_i && !clear_all_n_i |=> q == 4'h0) else $error("clear");
    a_preset_load: assert property (clk_en_i && ld |=> q == $past(preset_value_i)) else $error("load");
    a_low_step: assert property (go && $fell(c1) |=> q.lower != $past(q.lower)) else $error("lo");
    a_low_hold: assert property (go && !$fell(c1) |=> $stable(q.lower)) else $error("lo hold");
    a_up_hold: assert property (go && !$fell(c2) |=> $stable(q.upper)) else $error("up hold");
    a_up_step: assert property (go && $fell(c2) |=>
        q.upper == ($past(q.upper) >= lim ? 3'h0 : $past(q.upper) + 3'h1)) else $error("up");
    a_load_keep: assert property (clk_en_i && ld ##1 s_quiet |=> $stable(q)) else $error("keep");
    a_no_enable: assert property (!clk_en_i |=> $stable(q)) else $error("en");
endmodule
bind prc_counter prc_chk #(.DECADE_MODE(DECADE_MODE)) u_chk (.*);
`default_nettype wire

// *** test/prc_feed.sv ***
// Outside cascade: count bit 0 drives the second-stage clock.
`timescale 1ns/1ns
`default_nettype none
module prc_feed (input wire prc_pkg::prc_count_t count_i, output logic stage2_clk_n_o);
    assign stage2_clk_n_o = count_i.lower;
endmodule
`default_nettype wire

// *** test/presettable_ripple_counter_test.sv ***
// Bench: decade and binary builds cascaded by partners, plus bi-quinary; extra cycles allowed for ripple.
`timescale 1ns/1ns
`default_nettype none
module presettable_ripple_counter_test;
    logic clk = 0, rst_n = 0, en = 1, c1 = 1, ld_n = 1, clr_n = 1;
    logic c2q = 1;
    prc_pkg::prc_count_t pv = 4'h0, q, qb, qq;
    wire logic c2, cb;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    initial forever #25 clk = ~clk;
    prc_counter dut (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en), .first_stage_clk_n_i(c1),
        .second_stage_clk_n_i(c2), .preset_strobe_n_i(ld_n), .clear_all_n_i(clr_n), .preset_value_i(pv),
        .count_value_o(q));
    prc_feed partner (.count_i(q), .stage2_clk_n_o(c2));
    prc_counter #(.DECADE_MODE(1'b0)) dut_bin (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
        .first_stage_clk_n_i(c1), .second_stage_clk_n_i(cb), .preset_strobe_n_i(ld_n),
        .clear_all_n_i(clr_n), .preset_value_i(pv), .count_value_o(qb));
    prc_feed partner_bin (.count_i(qb), .stage2_clk_n_o(cb));
    // Bi-quinary wiring: top bit clocks the first stage, the bench clocks the second
    prc_counter dut_bq (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en), .first_stage_clk_n_i(qq.upper[2]),
        .second_stage_clk_n_i(c2q), .preset_strobe_n_i(ld_n), .clear_all_n_i(clr_n), .preset_value_i(pv),
        .count_value_o(qq));
    task automatic chk(string n, logic [3:0] got, logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin bad_count++; $display("mismatch %s exp %h got %h", n, exp, got); end
    endtask
    // Extra cycles let the ripple through the partner settle
    task automatic pulse();
        @(posedge clk) c1 <= 0; @(posedge clk) c1 <= 1; repeat (2) @(posedge clk);
    endtask
    task automatic t_bcd();
        for (int i = 1; i <= 16; i++) begin
            pulse();
            chk("bcd", q, 4'(i % 10));
            chk("bin", qb, 4'(i % 16));
        end
    endtask
    task automatic t_biq();
        for (int k = 1; k <= 10; k++) begin
            @(posedge clk) c2q <= 0;
            @(posedge clk) c2q <= 1;
            repeat (2) @(posedge clk);
            chk("biq", qq, 4'(((k % 10) % 5) * 2 + ((k % 10) >= 5 ? 1 : 0)));
        end
    endtask
    task automatic t_load();
        @(posedge clk) begin pv <= 4'h7; ld_n <= 0; end
        pulse(); chk("load", q, 4'h7);
        @(posedge clk) ld_n <= 1;
        chk("load bq", qq, 4'h7);
        pulse(); chk("resume", q, 4'h8);
        chk("resume bin", qb, 4'h8);
        @(posedge clk) begin clr_n <= 0; ld_n <= 0; end
        repeat (2) @(posedge clk); chk("clear", q, 4'h0);
        chk("clear bin", qb, 4'h0);
        chk("clear bq", qq, 4'h0);
        @(posedge clk) begin clr_n <= 1; ld_n <= 1; end
    endtask
    task automatic t_freeze();
        @(posedge clk) en <= 0;
        pulse(); chk("freeze", q, 4'h0);
        @(posedge clk) en <= 1;
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) if (++cyc > 2000) begin bad_count++; final_report(); end
    initial begin repeat (2) @(posedge clk); rst_n <= 1; t_bcd(); t_load(); t_freeze(); t_biq(); final_report(); end
endmodule
`default_nettype wire
